// ===== logic/pss_pkg.sv
package pss_pkg;
   // raw event and level inputs from protection and monitor logic
   typedef struct packed {
      logic vout_ov;
      logic vout_uv;
      logic oc_fault;
      logic oc_warn;
      logic fet_fault;
      logic comm_err;
      logic uv_in_fault;
      logic gate_off;
      logic power_good_sense_input;
      logic input_active;
      logic vendor_status_summary;
      logic temp_active;
      logic other_status_pending_flag;
   } pss_events_t;
endpackage : pss_pkg

// ===== logic/pss_regs.svh
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
`define PSS_OFF_STATUS_WORD 8'h79
`define PSS_OFF_VOUT_STATUS 8'h7a
`define PSS_OFF_IOUT_STATUS 8'h7b
`define PSS_RST_WORD 16'h0000
`define PSS_RST_BYTE 8'h00
`define PSS_W_VOUT 15
`define PSS_W_IOUT 14
`define PSS_W_INPUT 13
`define PSS_W_VENDOR 12
`define PSS_W_PGOOD 11
`define PSS_W_FET 8
`define PSS_B_GATE_OFF 6
`define PSS_B_OC_FAULT 4
`define PSS_B_UV_FAULT 3
`define PSS_B_TEMP 2
`define PSS_B_COMM 1
`define PSS_B_OTHER 0
`define PSS_V_OV 6
`define PSS_V_UV 5
`define PSS_I_OC_FAULT 7
`define PSS_I_OC_WARN 5
`endif

// ===== logic/pss_status.sv
`timescale 1ns/1ps
`include "pss_regs.svh"
// Contract
// (RULE1) bit 15 live OR of voltage status
// (RULE2) bit 14 live OR of current status
// (RULE3) bit 13 live input status summary
// (RULE4) bit 12 live vendor status summary
// (RULE5) bit 11 set while power not good
// (RULE6) bit 8 latches pass transistor fault
// (RULE7) word bits 10,9,7,5 read zero
// (RULE8) word low byte equals status byte
// (RULE9) all status registers reset to zero
// (RULE10) voltage bit 6 latches overvoltage
// (RULE11) voltage bit 5 latches undervoltage
// (RULE12) bits 4 to 0 read zero
// (RULE13) voltage bit 7, current bit 6 zero
// (RULE14) current bit 7 latches overcurrent shutdown
// (RULE15) current bit 5 latches overcurrent warning
// (RULE16) comm fault latches on bus error
// (RULE17) gate off bit is live
// (RULE18) latched bits hold until clear command
module pss_status
   import pss_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire pss_events_t events_in,
   input wire logic clear_faults_in,
   input wire logic [7:0] rd_addr_in,
   output logic [15:0] status_summary_word_out,
   output logic [7:0] output_voltage_status_out,
   output logic [7:0] output_current_status_out,
   output logic [15:0] rd_data_out
);
   // latched bits
   logic vout_ov, vout_uv, oc_fault, oc_warn, fet_fault, comm_fault;
   logic uv_fault;

   // sticky capture, set wins over clear
   wire next_vout_ov = events_in.vout_ov | (vout_ov & ~clear_faults_in);
   wire next_vout_uv = events_in.vout_uv | (vout_uv & ~clear_faults_in);
   wire next_oc_fault = events_in.oc_fault | (oc_fault & ~clear_faults_in);
   wire next_oc_warn = events_in.oc_warn | (oc_warn & ~clear_faults_in);
   wire next_fet = events_in.fet_fault | (fet_fault & ~clear_faults_in);
   wire next_comm = events_in.comm_err | (comm_fault & ~clear_faults_in);
   wire next_uv = events_in.uv_in_fault | (uv_fault & ~clear_faults_in);

   // register images built from latches and live levels
   wire [7:0] next_vout_reg = {1'b0, next_vout_ov, next_vout_uv, 5'b0_0000};
   wire [7:0] next_iout_reg = {next_oc_fault, 1'b0, next_oc_warn,
                               5'b0_0000};
   wire power_not_good_flag = ~events_in.power_good_sense_input;
   wire [7:0] next_byte = {1'b0, events_in.gate_off, 1'b0, next_oc_fault,
                           next_uv, events_in.temp_active, next_comm,
                           events_in.other_status_pending_flag};
   wire [15:0] next_word = {|next_vout_reg, |next_iout_reg,
                            events_in.input_active,
                            events_in.vendor_status_summary,
                            power_not_good_flag, 2'b00, next_fet,
                            next_byte};
   wire sel_word = rd_addr_in == `PSS_OFF_STATUS_WORD;
   wire sel_vout = rd_addr_in == `PSS_OFF_VOUT_STATUS;
   wire sel_iout = rd_addr_in == `PSS_OFF_IOUT_STATUS;
   wire [15:0] next_rd = sel_word ? next_word :
                         sel_vout ? {8'h00, next_vout_reg} :
                         sel_iout ? {8'h00, next_iout_reg} : 16'h0000;

   // latch flops (RULE6) (RULE10) (RULE11) (RULE14) (RULE15) (RULE16)
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {vout_ov, vout_uv, oc_fault, oc_warn} <= 4'h0;
         {fet_fault, comm_fault, uv_fault} <= 3'b000;
      end else begin
         {vout_ov, vout_uv, oc_fault, oc_warn} <=
            {next_vout_ov, next_vout_uv, next_oc_fault, next_oc_warn};
         {fet_fault, comm_fault, uv_fault} <= {next_fet, next_comm, next_uv};
      end
   end

   // summary word register (RULE1) (RULE2) (RULE3) (RULE4) (RULE5) (RULE9)
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         status_summary_word_out <= `PSS_RST_WORD;
      end else begin
         status_summary_word_out <= next_word; // RULE8 RULE7 RULE17
      end
   end

   // output voltage status register (RULE9)
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         output_voltage_status_out <= `PSS_RST_BYTE;
      end else begin
         output_voltage_status_out <= next_vout_reg; // RULE12 RULE13
      end
   end

   // output current status register (RULE9)
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         output_current_status_out <= `PSS_RST_BYTE;
      end else begin
         output_current_status_out <= next_iout_reg; // RULE18
      end
   end

   // read data register, unmapped offsets read zero
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_data_out <= `PSS_RST_WORD;
      end else begin
         rd_data_out <= next_rd;
      end
   end

   // summary bits track the detail registers
   a_vout_summary: assert property (@(posedge sys_clk_in) // RULE1
      disable iff (!rst_b_in) status_summary_word_out[`PSS_W_VOUT] ==
      |output_voltage_status_out) else $error("vout summary wrong");
   a_iout_summary: assert property (@(posedge sys_clk_in) // RULE2
      disable iff (!rst_b_in) status_summary_word_out[`PSS_W_IOUT] ==
      |output_current_status_out) else $error("iout summary wrong");
   a_oc_mirror: assert property (@(posedge sys_clk_in) // RULE8
      disable iff (!rst_b_in) status_summary_word_out[`PSS_B_OC_FAULT] ==
      output_current_status_out[`PSS_I_OC_FAULT]) else $error("oc mirror");

   // live bits show the level of the previous edge, once out of reset
   a_input_live: assert property (@(posedge sys_clk_in) // RULE3
      disable iff (!rst_b_in) rst_b_in && $past(rst_b_in) |->
      status_summary_word_out[`PSS_W_INPUT] ==
      $past(events_in.input_active)) else $error("input bit");
   a_vendor_live: assert property (@(posedge sys_clk_in) // RULE4
      disable iff (!rst_b_in) rst_b_in && $past(rst_b_in) |->
      status_summary_word_out[`PSS_W_VENDOR] ==
      $past(events_in.vendor_status_summary)) else $error("vendor");
   a_pgood_live: assert property (@(posedge sys_clk_in) // RULE5
      disable iff (!rst_b_in) rst_b_in && $past(rst_b_in) |->
      status_summary_word_out[`PSS_W_PGOOD] ==
      !$past(events_in.power_good_sense_input)) else $error("pgood");
   a_gate_live: assert property (@(posedge sys_clk_in) // RULE17
      disable iff (!rst_b_in) rst_b_in && $past(rst_b_in) |->
      status_summary_word_out[`PSS_B_GATE_OFF] ==
      $past(events_in.gate_off)) else $error("gate off");
   a_temp_live: assert property (@(posedge sys_clk_in) // RULE8
      disable iff (!rst_b_in) rst_b_in && $past(rst_b_in) |->
      status_summary_word_out[`PSS_B_TEMP] ==
      $past(events_in.temp_active)) else $error("temp bit");
   a_other_live: assert property (@(posedge sys_clk_in) // RULE8
      disable iff (!rst_b_in) rst_b_in && $past(rst_b_in) |->
      status_summary_word_out[`PSS_B_OTHER] ==
      $past(events_in.other_status_pending_flag)) else $error("other bit");

   // reserved positions never set
   a_reserved_zero: assert property (@(posedge sys_clk_in) // RULE7
      disable iff (!rst_b_in) status_summary_word_out[10:9] == 2'b00 &&
      !status_summary_word_out[7] && !status_summary_word_out[5] &&
      output_voltage_status_out[4:0] == 5'h00 &&
      output_current_status_out[4:0] == 5'h00 &&
      !output_voltage_status_out[7] && !output_current_status_out[6])
      else $error("reserved bit set");

   // latched bits set one edge after their event
   a_ov_latch: assert property (@(posedge sys_clk_in) // RULE10
      disable iff (!rst_b_in) rst_b_in && events_in.vout_ov |=>
      output_voltage_status_out[`PSS_V_OV]) else $error("ov latch");
   a_uv_latch: assert property (@(posedge sys_clk_in) // RULE11
      disable iff (!rst_b_in) rst_b_in && events_in.vout_uv |=>
      output_voltage_status_out[`PSS_V_UV]) else $error("uv latch");
   a_oc_latch: assert property (@(posedge sys_clk_in) // RULE14
      disable iff (!rst_b_in) rst_b_in && events_in.oc_fault |=>
      output_current_status_out[`PSS_I_OC_FAULT] &&
      status_summary_word_out[`PSS_B_OC_FAULT]) else $error("oc");
   a_warn_latch: assert property (@(posedge sys_clk_in) // RULE15
      disable iff (!rst_b_in) rst_b_in && events_in.oc_warn |=>
      output_current_status_out[`PSS_I_OC_WARN]) else $error("oc warn");
   a_fet_latch: assert property (@(posedge sys_clk_in) // RULE6
      disable iff (!rst_b_in) rst_b_in && events_in.fet_fault |=>
      status_summary_word_out[`PSS_W_FET]) else $error("fet latch");
   a_comm_latch: assert property (@(posedge sys_clk_in) // RULE16
      disable iff (!rst_b_in) rst_b_in && events_in.comm_err |=>
      status_summary_word_out[`PSS_B_COMM]) else $error("comm latch");
   a_uvin_latch: assert property (@(posedge sys_clk_in) // RULE8
      disable iff (!rst_b_in) rst_b_in && events_in.uv_in_fault |=>
      status_summary_word_out[`PSS_B_UV_FAULT]) else $error("uv in latch");

   // latched bits hold until a clear edge
   a_fet_hold: assert property (@(posedge sys_clk_in) // RULE6
      disable iff (!rst_b_in) status_summary_word_out[`PSS_W_FET] &&
      !clear_faults_in |=> status_summary_word_out[`PSS_W_FET])
      else $error("fet");
   a_ov_hold: assert property (@(posedge sys_clk_in) // RULE18
      disable iff (!rst_b_in) output_voltage_status_out[`PSS_V_OV] &&
      !clear_faults_in |=> output_voltage_status_out[`PSS_V_OV])
      else $error("ov hold");
   a_uv_hold: assert property (@(posedge sys_clk_in) // RULE18
      disable iff (!rst_b_in) output_voltage_status_out[`PSS_V_UV] &&
      !clear_faults_in |=> output_voltage_status_out[`PSS_V_UV])
      else $error("uv hold");
   a_oc_hold: assert property (@(posedge sys_clk_in) // RULE18
      disable iff (!rst_b_in) output_current_status_out[`PSS_I_OC_FAULT] &&
      !clear_faults_in |=> output_current_status_out[`PSS_I_OC_FAULT])
      else $error("oc hold");
   a_warn_hold: assert property (@(posedge sys_clk_in) // RULE18
      disable iff (!rst_b_in) output_current_status_out[`PSS_I_OC_WARN] &&
      !clear_faults_in |=> output_current_status_out[`PSS_I_OC_WARN])
      else $error("warn hold");
   a_comm_hold: assert property (@(posedge sys_clk_in) // RULE16
      disable iff (!rst_b_in) status_summary_word_out[`PSS_B_COMM] &&
      !clear_faults_in |=> status_summary_word_out[`PSS_B_COMM])
      else $error("comm hold");
   a_clear_drop: assert property (@(posedge sys_clk_in) // RULE18
      disable iff (!rst_b_in) clear_faults_in && !events_in.comm_err |=>
      !status_summary_word_out[`PSS_B_COMM]) else $error("clear");

   // reset and the first edge after it show zeros
   a_reset_zero: assert property (@(posedge sys_clk_in) // RULE9
      disable iff (!rst_b_in) !rst_b_in || !$past(rst_b_in) |->
      status_summary_word_out == `PSS_RST_WORD &&
      output_voltage_status_out == `PSS_RST_BYTE &&
      output_current_status_out == `PSS_RST_BYTE) else $error("reset value");

   // read data mirrors the register chosen one edge earlier
   a_rd_word: assert property (@(posedge sys_clk_in)
      disable iff (!rst_b_in) rst_b_in && $past(rst_b_in) &&
      $past(rd_addr_in) == `PSS_OFF_STATUS_WORD |->
      rd_data_out == status_summary_word_out) else $error("read word");
   a_rd_vout: assert property (@(posedge sys_clk_in)
      disable iff (!rst_b_in) rst_b_in && $past(rst_b_in) &&
      $past(rd_addr_in) == `PSS_OFF_VOUT_STATUS |->
      rd_data_out == {8'h00, output_voltage_status_out})
      else $error("read vout");
   a_rd_iout: assert property (@(posedge sys_clk_in)
      disable iff (!rst_b_in) rst_b_in && $past(rst_b_in) &&
      $past(rd_addr_in) == `PSS_OFF_IOUT_STATUS |->
      rd_data_out == {8'h00, output_current_status_out})
      else $error("read iout");

   // main scenarios
   c_ov_seen: cover property (@(posedge sys_clk_in)
      output_voltage_status_out[`PSS_V_OV]);
   c_oc_warn: cover property (@(posedge sys_clk_in)
      output_current_status_out[`PSS_I_OC_WARN]);
   c_clear: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      status_summary_word_out[`PSS_B_COMM] ##1 clear_faults_in ##1
      !status_summary_word_out[`PSS_B_COMM]);
   c_set_wins: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      clear_faults_in && events_in.comm_err ##1
      status_summary_word_out[`PSS_B_COMM]);
   c_pgood_bad: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      status_summary_word_out[`PSS_W_PGOOD]);
endmodule : pss_status

// ===== testbench/pss_host.sv
`timescale 1ns/1ps
// host side: register reads and the fault-clear command
module pss_host (
   input wire logic sys_clk_in,
   input wire logic [15:0] rd_data_in,
   output logic [7:0] rd_addr_out = 8'h00,
   output logic clear_out = 1'b0
);
   // data lands one edge after the address is taken
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge sys_clk_in) rd_addr_out <= a;
      @(posedge sys_clk_in);
      @(negedge sys_clk_in) d = rd_data_in;
   endtask : rd
   // one-cycle clear pulse
   task automatic clr();
      @(posedge sys_clk_in) clear_out <= 1'b1;
      @(posedge sys_clk_in) clear_out <= 1'b0;
   endtask : clr
endmodule : pss_host

// ===== testbench/pss_status_tb.sv
`timescale 1ns/1ps
module pss_status_tb;
   import pss_pkg::*;
   typedef struct packed {
      pss_events_t e;
      logic [15:0] w;
      logic [7:0] v;
      logic [7:0] c;
   } pss_row_t;
   logic sys_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   pss_events_t ev = 13'h0010;
   logic clr;
   logic [7:0] addr, vout, iout;
   logic [15:0] word, rd, d;
   int mismatches = 0;
   int checks = 0;
   // events, then expected word, voltage and current bytes
   pss_row_t rows [8] = '{
      '{13'h1010, 16'h8000, 8'h40, 8'h00},
      '{13'h0810, 16'h8000, 8'h20, 8'h00},
      '{13'h0410, 16'h4010, 8'h00, 8'h80},
      '{13'h0210, 16'h4000, 8'h00, 8'h20},
      '{13'h0110, 16'h0100, 8'h00, 8'h00},
      '{13'h00d0, 16'h000a, 8'h00, 8'h00},
      '{13'h002f, 16'h3845, 8'h00, 8'h00},
      '{13'h0000, 16'h0800, 8'h00, 8'h00}};
   always #12.5 sys_clk_in = ~sys_clk_in;
   pss_status u_pss_status (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
      .events_in(ev), .clear_faults_in(clr), .rd_addr_in(addr),
      .status_summary_word_out(word), .output_voltage_status_out(vout),
      .output_current_status_out(iout), .rd_data_out(rd));
   pss_host u_pss_host (.sys_clk_in(sys_clk_in), .rd_data_in(rd),
      .rd_addr_out(addr), .clear_out(clr));
   // compare and count
   task automatic chk(input string n, input logic [15:0] x,
         input logic [15:0] g);
      checks++;
      if (g !== x) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   // run is under a hundred cycles
   initial begin
      #40000;
      mismatches++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge sys_clk_in);
      @(negedge sys_clk_in) chk("rst word", 16'h0000, word);
      chk("rst vout", 16'h0000, {8'h00, vout});
      chk("rst iout", 16'h0000, {8'h00, iout});
      chk("rst rd", 16'h0000, rd);
      @(posedge sys_clk_in) rst_b_in <= 1'b1;
      // each row: apply events with a clear so old latches go
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk_in) ev <= rows[i].e;
         u_pss_host.clr();
         @(negedge sys_clk_in);
         chk("word", rows[i].w, word);
         chk("vout", {8'h00, rows[i].v}, {8'h00, vout});
         chk("iout", {8'h00, rows[i].c}, {8'h00, iout});
         u_pss_host.rd(8'h79, d);
         chk("word rd", rows[i].w, d);
      end
      $display("rows done");
      // pulses latch and hold until cleared
      @(posedge sys_clk_in) ev <= 13'h1310;
      @(posedge sys_clk_in) ev <= 13'h0010;
      repeat (3) @(posedge sys_clk_in);
      @(negedge sys_clk_in) chk("held", 16'hc100, word);
      u_pss_host.rd(8'h7a, d);
      chk("vout rd", 16'h0040, d);
      u_pss_host.rd(8'h7b, d);
      chk("iout rd", 16'h0020, d);
      u_pss_host.rd(8'h7c, d);
      chk("unmapped", 16'h0000, d);
      u_pss_host.clr();
      @(negedge sys_clk_in) chk("cleared", 16'h0000, word);
      $display("latch done");
      // reset in mid-run wipes a fresh latch
      @(posedge sys_clk_in) ev <= 13'h0410;
      @(posedge sys_clk_in) rst_b_in <= 1'b0;
      @(negedge sys_clk_in) chk("mid rst", 16'h0000, word);
      chk("iout rst", 16'h0000, {8'h00, iout});
      @(posedge sys_clk_in) rst_b_in <= 1'b1;
      // release edge still shows reset, the next one relatches
      @(negedge sys_clk_in) chk("rel edge", 16'h0000, word);
      @(negedge sys_clk_in) chk("relatch", 16'h4010, word);
      chk("iout relatch", 16'h0080, {8'h00, iout});
      $display("reset done");
      stop_test();
   end
endmodule : pss_status_tb
